// file: port_stats_pkg.sv
// constants and types for the port statistics counter bank
// Function
// - count rx octets by priority, bad included
// - count short rx frames with good check
// - count short rx fragments with errors
// - count long rx frames with good check
// - count long rx frames with errors
// - count legal rx frames with bad symbols
// - split legal bad-check rx frames by alignment
// - count rx mac control frames
// - count fully qualified rx pause frames
// - count good rx bcast, non-control mcast, ucast
// - bin every legal-length rx frame by length
// - count good tx octets by priority
// - count tx collisions after 512 bit times
// - count transmitted pause frames
// - count good tx bcast, mcast, ucast
// - count tx frames deferred by busy medium
// - count all tx collisions, half duplex
// - count tx frames lost to excess collisions
// - count tx successes after one, many collisions
// - keep two 16-bit resource drop counters
// - drop counters carry no overflow, valid flags
// - counter word: overflow, valid, 30-bit value
// - reading a per-port counter clears it
// - reading drop counters leaves them intact
package port_stats_pkg;
  localparam logic [9:0] RX_LO_OCT = 10'h000;
  localparam logic [9:0] RX_HI_OCT = 10'h001;
  localparam logic [9:0] RX_SHORT_GOOD = 10'h002;
  localparam logic [9:0] RX_SHORT_BAD = 10'h003;
  localparam logic [9:0] RX_LONG_GOOD = 10'h004;
  localparam logic [9:0] RX_LONG_BAD = 10'h005;
  localparam logic [9:0] RX_BAD_SYM = 10'h006;
  localparam logic [9:0] RX_FCS_FAIL = 10'h007;
  localparam logic [9:0] RX_MISALIGN = 10'h008;
  localparam logic [9:0] RX_MAC_CTRL = 10'h009;
  localparam logic [9:0] RX_PAUSE = 10'h00A;
  localparam logic [9:0] RX_BCAST = 10'h00B;
  localparam logic [9:0] RX_MCAST = 10'h00C;
  localparam logic [9:0] RX_UCAST = 10'h00D;
  localparam logic [9:0] RX_LEN_64 = 10'h00E;
  localparam logic [9:0] RX_LEN_65 = 10'h00F;
  localparam logic [9:0] RX_LEN_128 = 10'h010;
  localparam logic [9:0] RX_LEN_256 = 10'h011;
  localparam logic [9:0] RX_LEN_512 = 10'h012;
  localparam logic [9:0] RX_LEN_1024 = 10'h013;
  localparam logic [9:0] TX_LO_OCT = 10'h014;
  localparam logic [9:0] TX_HI_OCT = 10'h015;
  localparam logic [9:0] TX_LATE_COLL = 10'h016;
  localparam logic [9:0] TX_PAUSE = 10'h017;
  localparam logic [9:0] TX_BCAST = 10'h018;
  localparam logic [9:0] TX_MCAST = 10'h019;
  localparam logic [9:0] TX_UCAST = 10'h01A;
  localparam logic [9:0] TX_DEFER = 10'h01B;
  localparam logic [9:0] TX_ALL_COLL = 10'h01C;
  localparam logic [9:0] TX_MANY_COLL = 10'h01D;
  localparam logic [9:0] TX_ONE_COLL = 10'h01E;
  localparam logic [9:0] TX_MULTI_COLL = 10'h01F;
  localparam logic [9:0] TX_DROP_RES = 10'h100;
  localparam logic [9:0] RX_DROP_RES = 10'h103;
  // indirect control word: command in 12:10, offset in 9:0
  localparam int CMD_HI = 12;
  localparam int CMD_LO = 10;
  localparam logic [2:0] CMD_RD_MIB = 3'h7;
  localparam int NUM_CNT = 32;
  localparam int OVF_BIT = 31;
  localparam int VALID_BIT = 30;
  localparam logic [10:0] MIN_LEN = 11'h040;
  localparam logic [10:0] LIM_LEN = 11'h7D0;
  localparam logic [30:0] CNT_RST = 31'h00000000;
  localparam logic [15:0] DROP_RST = 16'h0000;
  typedef struct packed {
    logic done; logic [10:0] len; logic hi_prio; logic fcs_ok;
    logic sym_err; logic odd_bits; logic bcast; logic mcast;
    logic ctrl_type; logic pause_match;
  } rx_evt_t;
  typedef struct packed {
    logic done; logic [10:0] len; logic hi_prio; logic good;
    logic bcast; logic mcast; logic pause; logic deferred;
    logic excess; logic [4:0] coll_cnt; logic coll; logic late_coll;
  } tx_evt_t;
  typedef struct packed {
    logic wr; logic [15:0] data;
  } host_cmd_t;
  typedef struct packed {
    logic ovf; logic [29:0] val;
  } cnt_t;
  typedef struct packed {
    cnt_t [NUM_CNT-1:0] cnt; logic [15:0] tx_drop;
    logic [15:0] rx_drop; logic [31:0] data;
  } stat_state_t;
endpackage : port_stats_pkg

// file: port_statistics_counters.sv
// statistics counter bank with indirect read-clear access
`timescale 1ns/1ns
module port_statistics_counters import port_stats_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration
  input wire logic [10:0] max_frame_len,
  input wire logic half_duplex,
  // mac events, one-cycle pulses
  input wire rx_evt_t rx_evt,
  input wire tx_evt_t tx_evt,
  input wire logic tx_drop,
  input wire logic rx_drop,
  // indirect access
  input wire host_cmd_t ctrl_wr,
  output logic [15:0] indirect_data_high,
  output logic [15:0] indirect_data_low
);

  // ============================================================
  // helpers
  function automatic logic in_rng(input logic [10:0] v,
                                  input logic [10:0] lo,
                                  input logic [10:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction : in_rng

  function automatic logic [10:0] one(input logic b);
    one = {10'h000, b};
  endfunction : one

  stat_state_t st_r;
  stat_state_t st_nxt;
  logic [NUM_CNT-1:0][10:0] inc;
  logic [10:0] eff_max;
  logic [10:0] rlen;
  logic [10:0] tlen;
  logic rdone;
  logic tdone;
  logic r_short;
  logic r_long;
  logic r_legal;
  logic r_bad;
  logic r_good;
  logic rd_cmd;
  logic rd_pp;
  logic [9:0] rd_addr;
  logic [4:0] rd_idx;

  // ============================================================
  // frame classification
  // oversize limit never exceeds the hardware ceiling
  assign eff_max = (max_frame_len > LIM_LEN) ? LIM_LEN : max_frame_len;
  assign rlen = rx_evt.len;
  assign tlen = tx_evt.len;
  assign rdone = rx_evt.done;
  assign tdone = tx_evt.done;
  assign r_short = rlen < MIN_LEN;
  assign r_long = rlen > eff_max;
  assign r_legal = !r_short && !r_long;
  assign r_bad = !rx_evt.fcs_ok || rx_evt.sym_err || rx_evt.odd_bits;
  assign r_good = rdone && r_legal && !r_bad;

  always_comb begin
    inc = '0;
    inc[RX_LO_OCT[4:0]] = (rdone && !rx_evt.hi_prio) ? rlen : 11'h000;
    inc[RX_HI_OCT[4:0]] = (rdone && rx_evt.hi_prio) ? rlen : 11'h000;
    inc[RX_SHORT_GOOD[4:0]] = one(rdone && r_short && rx_evt.fcs_ok);
    inc[RX_SHORT_BAD[4:0]] = one(rdone && r_short && r_bad);
    inc[RX_LONG_GOOD[4:0]] = one(rdone && r_long && rx_evt.fcs_ok);
    inc[RX_LONG_BAD[4:0]] = one(rdone && r_long && r_bad);
    inc[RX_BAD_SYM[4:0]] = one(rdone && r_legal && rx_evt.sym_err);
    inc[RX_FCS_FAIL[4:0]] = one(rdone && r_legal && !rx_evt.fcs_ok &&
                                !rx_evt.odd_bits);
    inc[RX_MISALIGN[4:0]] = one(rdone && r_legal && !rx_evt.fcs_ok &&
                                rx_evt.odd_bits);
    inc[RX_MAC_CTRL[4:0]] = one(rdone && rx_evt.ctrl_type);
    inc[RX_PAUSE[4:0]] = one(rdone && rx_evt.ctrl_type &&
                             rx_evt.pause_match && !r_short &&
                             rx_evt.fcs_ok);
    inc[RX_BCAST[4:0]] = one(r_good && rx_evt.bcast);
    inc[RX_MCAST[4:0]] = one(r_good && rx_evt.mcast && !rx_evt.bcast &&
                             !rx_evt.ctrl_type);
    inc[RX_UCAST[4:0]] = one(r_good && !rx_evt.mcast && !rx_evt.bcast);
    inc[RX_LEN_64[4:0]] = one(rdone && rlen == MIN_LEN);
    inc[RX_LEN_65[4:0]] = one(rdone && in_rng(rlen, 11'h041, 11'h07F));
    inc[RX_LEN_128[4:0]] = one(rdone && in_rng(rlen, 11'h080, 11'h0FF));
    inc[RX_LEN_256[4:0]] = one(rdone && in_rng(rlen, 11'h100, 11'h1FF));
    inc[RX_LEN_512[4:0]] = one(rdone && in_rng(rlen, 11'h200, 11'h3FF));
    inc[RX_LEN_1024[4:0]] = one(rdone && in_rng(rlen, 11'h400, eff_max));
    inc[TX_LO_OCT[4:0]] = (tdone && tx_evt.good && !tx_evt.hi_prio) ?
                          tlen : 11'h000;
    inc[TX_HI_OCT[4:0]] = (tdone && tx_evt.good && tx_evt.hi_prio) ?
                          tlen : 11'h000;
    inc[TX_LATE_COLL[4:0]] = one(tx_evt.late_coll);
    inc[TX_PAUSE[4:0]] = one(tdone && tx_evt.pause);
    inc[TX_BCAST[4:0]] = one(tdone && tx_evt.good && tx_evt.bcast);
    inc[TX_MCAST[4:0]] = one(tdone && tx_evt.good && tx_evt.mcast &&
                             !tx_evt.bcast);
    inc[TX_UCAST[4:0]] = one(tdone && tx_evt.good && !tx_evt.mcast &&
                             !tx_evt.bcast);
    inc[TX_DEFER[4:0]] = one(tdone && tx_evt.deferred);
    inc[TX_ALL_COLL[4:0]] = one(tx_evt.coll && half_duplex);
    inc[TX_MANY_COLL[4:0]] = one(tdone && tx_evt.excess);
    inc[TX_ONE_COLL[4:0]] = one(tdone && tx_evt.good &&
                                tx_evt.coll_cnt == 5'h01);
    inc[TX_MULTI_COLL[4:0]] = one(tdone && tx_evt.good &&
                                  tx_evt.coll_cnt > 5'h01);
  end

  // ============================================================
  // indirect read decode
  assign rd_cmd = ctrl_wr.wr &&
                  (ctrl_wr.data[CMD_HI:CMD_LO] == CMD_RD_MIB);
  assign rd_addr = ctrl_wr.data[9:0];
  assign rd_pp = rd_cmd && (rd_addr[9:5] == 5'h00);
  assign rd_idx = rd_addr[4:0];

  // ============================================================
  // next state
  always_comb begin
    logic [30:0] sum;
    sum = CNT_RST;
    st_nxt = st_r;
    for (int i = 0; i < NUM_CNT; i++) begin
      sum = {1'b0, st_r.cnt[i].val} + {20'h00000, inc[i]};
      if (rd_pp && rd_idx == 5'(i)) begin
        // this cycle's event survives the clear
        st_nxt.cnt[i].val = {19'h00000, inc[i]};
        st_nxt.cnt[i].ovf = 1'b0;
      end else begin
        st_nxt.cnt[i].val = sum[29:0];
        st_nxt.cnt[i].ovf = st_r.cnt[i].ovf | sum[30];
      end
    end
    st_nxt.tx_drop = st_r.tx_drop + {15'h0000, tx_drop};
    st_nxt.rx_drop = st_r.rx_drop + {15'h0000, rx_drop};
    if (rd_pp) begin
      st_nxt.data = {st_r.cnt[rd_idx].ovf, 1'b1, st_r.cnt[rd_idx].val};
    end else if (rd_cmd && rd_addr == TX_DROP_RES) begin
      st_nxt.data = {16'h0000, st_r.tx_drop};
    end else if (rd_cmd && rd_addr == RX_DROP_RES) begin
      st_nxt.data = {16'h0000, st_r.rx_drop};
    end else if (rd_cmd) begin
      // unmapped offsets read as zero
      st_nxt.data = 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign indirect_data_high = st_r.data[31:16];
  assign indirect_data_low = st_r.data[15:0];

  // ============================================================
  // checks
  logic quiet;
  assign quiet = !rdone && !tdone && !tx_evt.coll && !tx_evt.late_coll;

  property p_rx_oct;
    @(posedge clk) disable iff (!rst_b)
    rdone && !rx_evt.hi_prio && !rd_cmd &&
    st_r.cnt[RX_LO_OCT[4:0]].val < 30'h0000FFFF
    |=> st_r.cnt[RX_LO_OCT[4:0]].val ==
        $past(st_r.cnt[RX_LO_OCT[4:0]].val) + 30'($past(rlen));
  endproperty
  a_rx_oct: assert property (p_rx_oct)
    else $error("rx low octets not added");

  property p_frag;
    @(posedge clk) disable iff (!rst_b)
    rdone && rlen < MIN_LEN && !rx_evt.fcs_ok && !rd_cmd &&
    st_r.cnt[RX_SHORT_BAD[4:0]].val < 30'h0000FFFF
    |=> st_r.cnt[RX_SHORT_BAD[4:0]].val ==
        $past(st_r.cnt[RX_SHORT_BAD[4:0]].val) + 30'h1;
  endproperty
  a_frag: assert property (p_frag)
    else $error("fragment not counted");

  property p_misalign;
    @(posedge clk) disable iff (!rst_b)
    rdone && rlen == 11'h400 && !rx_evt.fcs_ok && rx_evt.odd_bits &&
    eff_max > 11'h400 && !rd_cmd
    |=> $stable(st_r.cnt[RX_FCS_FAIL[4:0]].val);
  endproperty
  a_misalign: assert property (p_misalign)
    else $error("misaligned frame counted as check failure");

  property p_pause_qual;
    @(posedge clk) disable iff (!rst_b)
    !rx_evt.ctrl_type && !rd_cmd
    |=> $stable(st_r.cnt[RX_PAUSE[4:0]].val);
  endproperty
  a_pause_qual: assert property (p_pause_qual)
    else $error("pause counted without control type");

  property p_bin64;
    @(posedge clk) disable iff (!rst_b)
    rdone && rlen == MIN_LEN && !rd_cmd &&
    st_r.cnt[RX_LEN_64[4:0]].val < 30'h0000FFFF
    ##1 !rdone && !rd_cmd
    |=> st_r.cnt[RX_LEN_64[4:0]].val ==
        $past(st_r.cnt[RX_LEN_64[4:0]].val, 2) + 30'h1;
  endproperty
  a_bin64: assert property (p_bin64)
    else $error("64 octet bin not counted");

  property p_late;
    @(posedge clk) disable iff (!rst_b)
    tx_evt.late_coll && !rd_cmd &&
    st_r.cnt[TX_LATE_COLL[4:0]].val < 30'h0000FFFF
    |=> st_r.cnt[TX_LATE_COLL[4:0]].val ==
        $past(st_r.cnt[TX_LATE_COLL[4:0]].val) + 30'h1;
  endproperty
  a_late: assert property (p_late)
    else $error("late collision lost");

  property p_half;
    @(posedge clk) disable iff (!rst_b)
    !half_duplex && !rd_cmd
    |=> $stable(st_r.cnt[TX_ALL_COLL[4:0]].val);
  endproperty
  a_half: assert property (p_half)
    else $error("collision counted in full duplex");

  property p_one_coll;
    @(posedge clk) disable iff (!rst_b)
    tdone && tx_evt.good && tx_evt.coll_cnt == 5'h01 && !rd_cmd
    |=> $stable(st_r.cnt[TX_MULTI_COLL[4:0]].val);
  endproperty
  a_one_coll: assert property (p_one_coll)
    else $error("single collision counted as multiple");

  property p_drop_fmt;
    @(posedge clk) disable iff (!rst_b)
    rd_cmd && rd_addr == TX_DROP_RES
    |=> indirect_data_high == 16'h0000 &&
        indirect_data_low == $past(st_r.tx_drop);
  endproperty
  a_drop_fmt: assert property (p_drop_fmt)
    else $error("drop counter word malformed");

  property p_valid;
    @(posedge clk) disable iff (!rst_b)
    rd_pp |=> indirect_data_high[VALID_BIT-16] == 1'b1
      && indirect_data_high[OVF_BIT-16] == $past(st_r.cnt[rd_idx].ovf);
  endproperty
  a_valid: assert property (p_valid)
    else $error("counter word flags wrong");

  property p_clear;
    @(posedge clk) disable iff (!rst_b)
    rd_pp && rd_idx == RX_BCAST[4:0] && quiet
    |=> st_r.cnt[RX_BCAST[4:0]] == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counter not cleared by read");

  property p_keep_drop;
    @(posedge clk) disable iff (!rst_b)
    rd_cmd && rd_addr == RX_DROP_RES && !rx_drop
    |=> st_r.rx_drop == $past(st_r.rx_drop);
  endproperty
  a_keep_drop: assert property (p_keep_drop)
    else $error("drop counter changed by read");

  property p_atomic;
    @(posedge clk) disable iff (!rst_b)
    rd_pp && rd_idx == RX_LEN_64[4:0] && rdone && rlen == MIN_LEN
    |=> st_r.cnt[RX_LEN_64[4:0]].val == 30'h1;
  endproperty
  a_atomic: assert property (p_atomic)
    else $error("event during read lost");

  property p_short_good;
    @(posedge clk) disable iff (!rst_b)
    rdone && rlen < MIN_LEN && rx_evt.fcs_ok && !rd_cmd
    |=> st_r.cnt[RX_SHORT_GOOD[4:0]].val ==
        $past(st_r.cnt[RX_SHORT_GOOD[4:0]].val) + 30'h1;
  endproperty
  a_short_good: assert property (p_short_good)
    else $error("short good frame not counted");

  property p_long_bad;
    @(posedge clk) disable iff (!rst_b)
    rdone && rlen > eff_max && !rx_evt.fcs_ok && !rd_cmd
    |=> st_r.cnt[RX_LONG_BAD[4:0]].val ==
        $past(st_r.cnt[RX_LONG_BAD[4:0]].val) + 30'h1;
  endproperty
  a_long_bad: assert property (p_long_bad)
    else $error("long errored frame not counted");

  property p_sym;
    @(posedge clk) disable iff (!rst_b)
    rdone && rlen >= MIN_LEN && rlen <= eff_max && rx_evt.sym_err && !rd_cmd
    |=> st_r.cnt[RX_BAD_SYM[4:0]].val ==
        $past(st_r.cnt[RX_BAD_SYM[4:0]].val) + 30'h1;
  endproperty
  a_sym: assert property (p_sym)
    else $error("bad symbol frame not counted");

  property p_ctrl;
    @(posedge clk) disable iff (!rst_b)
    rdone && rx_evt.ctrl_type && !rd_cmd
    |=> st_r.cnt[RX_MAC_CTRL[4:0]].val ==
        $past(st_r.cnt[RX_MAC_CTRL[4:0]].val) + 30'h1;
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control frame not counted");

  property p_mcast_ctrl;
    @(posedge clk) disable iff (!rst_b)
    rdone && rx_evt.ctrl_type && !rd_cmd
    |=> $stable(st_r.cnt[RX_MCAST[4:0]].val);
  endproperty
  a_mcast_ctrl: assert property (p_mcast_ctrl)
    else $error("control frame counted as multicast");

  property p_tx_oct;
    @(posedge clk) disable iff (!rst_b)
    tdone && tx_evt.good && tx_evt.hi_prio && !rd_cmd
    |=> st_r.cnt[TX_HI_OCT[4:0]].val ==
        $past(st_r.cnt[TX_HI_OCT[4:0]].val) + 30'($past(tlen));
  endproperty
  a_tx_oct: assert property (p_tx_oct)
    else $error("tx high octets not added");

  property p_tx_pause;
    @(posedge clk) disable iff (!rst_b)
    tdone && tx_evt.pause && !rd_cmd
    |=> st_r.cnt[TX_PAUSE[4:0]].val ==
        $past(st_r.cnt[TX_PAUSE[4:0]].val) + 30'h1;
  endproperty
  a_tx_pause: assert property (p_tx_pause)
    else $error("tx pause frame not counted");

  property p_defer;
    @(posedge clk) disable iff (!rst_b)
    tdone && tx_evt.deferred && !rd_cmd
    |=> st_r.cnt[TX_DEFER[4:0]].val ==
        $past(st_r.cnt[TX_DEFER[4:0]].val) + 30'h1;
  endproperty
  a_defer: assert property (p_defer)
    else $error("deferred frame not counted");

  property p_tx_drop;
    @(posedge clk) disable iff (!rst_b)
    tx_drop
    |=> st_r.tx_drop == $past(st_r.tx_drop) + 16'h0001;
  endproperty
  a_tx_drop: assert property (p_tx_drop)
    else $error("tx resource drop not counted");

endmodule : port_statistics_counters

// file: host_model.sv
// host-side model: indirect counter reads over the control write path
`timescale 1ns/1ns
module host_model import port_stats_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // indirect access
  output host_cmd_t ctrl_wr,
  input wire logic [15:0] indirect_data_high,
  input wire logic [15:0] indirect_data_low
);
  initial ctrl_wr = '0;
  // ======================================================
  // control write, one cycle, data scrambled on release
  task automatic wr(input logic [15:0] d);
    @(negedge clk);
    ctrl_wr.wr = 1'b1;
    ctrl_wr.data = d;
    @(negedge clk);
    ctrl_wr.wr = 1'b0;
    ctrl_wr.data = ~d;
  endtask : wr
  // control write, then upper half, then lower half
  task automatic rd(input logic [9:0] off, output logic [31:0] w);
    wr({3'h0, CMD_RD_MIB, off});
    @(negedge clk);
    w[31:16] = indirect_data_high;
    // upper half again while not valid, per-port only
    for (int i = 0; i < 3 && !w[VALID_BIT] && off < 10'h020; i++) begin
      @(negedge clk);
      w[31:16] = indirect_data_high;
    end
    w[15:0] = indirect_data_low;
  endtask : rd
endmodule : host_model

// file: tb.sv
// self-checking bench for the port statistics counter bank
`timescale 1ns/1ns
module tb import port_stats_pkg::*; ;
  // ======================================================
  // signals
  logic clk;
  logic rst_b;
  logic [10:0] max_frame_len;
  logic half_duplex;
  rx_evt_t rx_evt;
  tx_evt_t tx_evt;
  logic tx_drop;
  logic rx_drop;
  host_cmd_t ctrl_wr;
  logic [15:0] indirect_data_high;
  logic [15:0] indirect_data_low;
  logic [29:0] exp_c [NUM_CNT];
  logic [31:0] held;
  int err_total;
  int samples_checked;

  port_statistics_counters dut_u (
    .clk(clk), .rst_b(rst_b), .max_frame_len(max_frame_len),
    .half_duplex(half_duplex), .rx_evt(rx_evt), .tx_evt(tx_evt),
    .tx_drop(tx_drop), .rx_drop(rx_drop), .ctrl_wr(ctrl_wr),
    .indirect_data_high(indirect_data_high),
    .indirect_data_low(indirect_data_low)
  );
  host_model host_u (
    .clk(clk), .rst_b(rst_b), .ctrl_wr(ctrl_wr),
    .indirect_data_high(indirect_data_high),
    .indirect_data_low(indirect_data_low)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ======================================================
  // tasks
  task automatic chk(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [9:0] off, input logic [31:0] exp);
    logic [31:0] w;
    host_u.rd(off, w);
    chk(w, exp, $sformatf("offset %h", off));
  endtask : rd_chk

  // every counter: valid set, value as modelled, then cleared
  task automatic chk_all();
    for (int i = 0; i < NUM_CNT; i++) begin
      rd_chk(10'(i), {2'b01, exp_c[i]});
      exp_c[i] = '0;
    end
  endtask : chk_all

  // f = hi, fcs ok, symbol err, odd bits, bcast, mcast, ctrl, pause
  task automatic rx(input logic [10:0] len, input logic [7:0] f);
    logic sh, lg, bad, good;
    sh = len < MIN_LEN;
    lg = len > max_frame_len;
    bad = !f[6] || f[5] || f[4];
    good = !sh && !lg && !bad;
    exp_c[f[7]] += 30'(len);
    if (sh && f[6]) exp_c[2]++;
    if (sh && bad) exp_c[3]++;
    if (lg && f[6]) exp_c[4]++;
    if (lg && bad) exp_c[5]++;
    if (!sh && !lg && f[5]) exp_c[6]++;
    if (!sh && !lg && !f[6]) exp_c[f[4] ? 8 : 7]++;
    if (f[1]) exp_c[9]++;
    if (f[1] && f[0] && !sh && f[6]) exp_c[10]++;
    if (good && f[3]) exp_c[11]++;
    if (good && f[2] && !f[3] && !f[1]) exp_c[12]++;
    if (good && !f[3] && !f[2]) exp_c[13]++;
    if (!sh && !lg)
      exp_c[len == 64 ? 14 : len < 128 ? 15 : len < 256 ? 16 :
            len < 512 ? 17 : len < 1024 ? 18 : 19]++;
    @(negedge clk);
    rx_evt = {1'b1, len, f[7:6], f[5:0]};
    @(negedge clk);
    rx_evt.done = 1'b0;
  endtask : rx

  // f = hi, good, bcast, mcast, pause, deferred, excess
  task automatic tx(input logic [10:0] len, input logic [6:0] f,
                    input logic [4:0] cc);
    if (f[5]) begin
      exp_c[f[6] ? 21 : 20] += 30'(len);
      exp_c[f[4] ? 24 : f[3] ? 25 : 26]++;
      if (cc == 1) exp_c[30]++;
      if (cc > 1) exp_c[31]++;
    end
    if (f[2]) exp_c[23]++;
    if (f[1]) exp_c[27]++;
    if (f[0]) exp_c[29]++;
    @(negedge clk);
    tx_evt = {1'b1, len, f, cc, 2'b00};
    @(negedge clk);
    tx_evt.done = 1'b0;
  endtask : tx

  task automatic coll(input logic late);
    if (half_duplex) exp_c[28]++;
    if (late) exp_c[22]++;
    @(negedge clk);
    tx_evt.coll = 1'b1;
    tx_evt.late_coll = late;
    @(negedge clk);
    tx_evt.coll = 1'b0;
    tx_evt.late_coll = 1'b0;
  endtask : coll

  task automatic drop(input logic t, input logic r);
    @(negedge clk);
    tx_drop = t;
    rx_drop = r;
    @(negedge clk);
    tx_drop = 1'b0;
    rx_drop = 1'b0;
  endtask : drop

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ======================================================
  // tests
  initial begin
    #100000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    rst_b = 1'b0;
    max_frame_len = 11'h5F2;
    half_duplex = 1'b1;
    rx_evt = '0;
    tx_evt = '0;
    tx_drop = 1'b0;
    rx_drop = 1'b0;
    err_total = 0;
    samples_checked = 0;
    foreach (exp_c[i]) exp_c[i] = '0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    chk_all();
    rd_chk(TX_DROP_RES, 32'h0000_0000);
    $display("test reset_values done");
    rx(11'h040, 8'b0100_1000);
    rx(11'h064, 8'b1100_0100);
    rx(11'h0C8, 8'b0100_0000);
    rx(11'h040, 8'b0100_0111);
    rx(11'h050, 8'b0100_0110);
    rx(11'h028, 8'b0100_0000);
    rx(11'h028, 8'b0000_0000);
    rx(11'h640, 8'b0100_0000);
    rx(11'h5F3, 8'b0100_0000);
    rx(11'h640, 8'b0000_0000);
    rx(11'h12C, 8'b0110_0000);
    rx(11'h258, 8'b0000_0000);
    rx(11'h400, 8'b0001_0000);
    rx(11'h5F2, 8'b0100_0000);
    rx(11'h07F, 8'b0100_0000);
    rx(11'h080, 8'b0100_0000);
    rx(11'h3FF, 8'b0100_0000);
    chk_all();
    $display("test rx_counters done");
    tx(11'h064, 7'b0110000, 5'h00);
    tx(11'h0C8, 7'b1101000, 5'h00);
    tx(11'h12C, 7'b0100000, 5'h01);
    tx(11'h190, 7'b0100010, 5'h03);
    tx(11'h040, 7'b0101100, 5'h00);
    tx(11'h1F4, 7'b0000001, 5'h10);
    coll(1'b0);
    coll(1'b1);
    @(negedge clk);
    half_duplex = 1'b0;
    coll(1'b0);
    chk_all();
    $display("test tx_counters done");
    drop(1'b1, 1'b1);
    drop(1'b1, 1'b0);
    drop(1'b1, 1'b0);
    rd_chk(TX_DROP_RES, 32'h0000_0003);
    rd_chk(TX_DROP_RES, 32'h0000_0003);
    rd_chk(10'h101, 32'h0000_0000);
    rd_chk(RX_DROP_RES, 32'h0000_0001);
    $display("test drop_counters done");
    rx(11'h040, 8'b0100_0000);
    held = {indirect_data_high, indirect_data_low};
    host_u.wr(16'h0C0E);
    @(negedge clk);
    chk({indirect_data_high, indirect_data_low}, held, "ignored cmd");
    fork
      rx(11'h040, 8'b0100_0000);
      rd_chk(RX_LEN_64, 32'h4000_0001);
    join
    exp_c[14] = 30'h0000_0001;
    chk_all();
    $display("test read_race done");
    tally_and_finish();
  end
endmodule : tb
